// *** psra_chk.sv ***
`timescale 1ns/100ps
module psra_chk
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [2:0] addr,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    import psra_pkg::*;
    // ****************************************
    // Register bus relations
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    wire dacc  = (wr_en | rd_en) & (addr == OFS_DATA);
    wire hi_wr = wr_en & (addr == OFS_PTR_HI);
    wire lo_wr = wr_en & (addr == OFS_PTR_LO);
    wire dead  = (addr == 3'h0) | (addr == 3'h5) | (addr == 3'h6) | (addr == OFS_CMD);

    chk_no_dual_strobe: assert property (!(wr_en && rd_en))
        else $error("read and write strobes together");
    chk_read_pulse: assert property (rd_en |=> !rd_en)
        else $error("read strobe longer than one cycle");
    chk_hi_then_lo: assert property (hi_wr |=> lo_wr)
        else $error("pointer high not followed by low");
    chk_lo_after_hi: assert property (lo_wr |-> $past(hi_wr))
        else $error("pointer low without high first");
    // Prefetch needs time before the first data read
    chk_load_gap: assert property (lo_wr |=> (!(rd_en && addr == OFS_DATA)) [*3])
        else $error("data read too soon after pointer load");
    chk_data_gap: assert property (dacc |=> (!dacc) [*2])
        else $error("data accesses too close");
    chk_rdata_holds: assert property (!rd_en |=> $stable(rdata))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (rd_en && dead |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_ptr_hi_form: assert property (rd_en && addr == OFS_PTR_HI |=> rdata[6:3] == 4'h0)
        else $error("pointer high read has stray bits");
    chk_hi_reserved: assert property (hi_wr |-> wdata[6:3] == 4'h0)
        else $error("pointer high write has stray bits");
endmodule

// *** psra_device.sv ***
`timescale 1ns/100ps
// Operation
// - Host reaches RAM only via pointer and data port
// - High byte 02H, low 03H commits address
// - Pointer load prefetches addressed byte into port
// - Auto-increment advances address; reads also prefetch next
// - Host reloads pointer when changing direction
// - Host waits three cycles before first read
// - Writes held, reads prefetched, host never stalls
// - Setup bit 0 halves arbitration clock
// - Host loads pointer high then low, then accesses
// - Pointer readable, shows incremented address
// - Commands select one of four 512-byte pages
// - Bit 5 offsets buffer by 256 bytes
// - Command 0010 0011 arms transmit, page 0 upper
// - Buffer start is page*512 plus flag*256
// - No page boundary check on stored data
// - Short-packet setups use 256-byte buffers
// - Unassigned RAM stays general host storage
module psra_device
#(
    parameter int RAM_AW    = psra_pkg::RAM_AW,
    parameter int RAM_DEPTH = psra_pkg::RAM_DEPTH
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    psra_if.dev                    bus,
    input  wire logic              net_wr_en,
    input  wire logic [RAM_AW-1:0] net_addr,
    input  wire logic [7:0]        net_wdata,
    output logic                   net_wr_ready,
    output logic [RAM_AW-1:0]      tx_start_addr,
    output logic [RAM_AW-1:0]      rx_start_addr,
    output logic                   tx_arm,
    output logic                   rx_arm,
    output logic                   slow_arb
);
    import psra_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [7:0]        mem_r [0:RAM_DEPTH-1];
    logic [RAM_AW-1:0] ptr_r,      ptr_nxt;
    logic [7:0]        hi_r,       hi_nxt;
    logic              ainc_r,     ainc_nxt;
    logic [7:0]        setup_r,    setup_nxt;
    logic [7:0]        data_r,     data_nxt;
    logic [7:0]        hold_r,     hold_nxt;
    logic [RAM_AW-1:0] wr_addr_r,  wr_addr_nxt;
    logic              fetch_r,    fetch_nxt;
    logic              wpend_r,    wpend_nxt;
    logic              phase_r,    phase_nxt;
    logic [7:0]        rdata_r,    rdata_nxt;
    logic [RAM_AW-1:0] tx_start_r, tx_start_nxt;
    logic [RAM_AW-1:0] rx_start_r, rx_start_nxt;
    logic              tx_arm_r,   tx_arm_nxt;
    logic              rx_arm_r,   rx_arm_nxt;
    logic              arb_tick;
    logic              mem_we;
    logic [RAM_AW-1:0] mem_waddr;
    logic [7:0]        mem_wdata;
    logic [RAM_AW-1:0] cmd_base;
    logic [RAM_AW-1:0] ptr_inc;

    // ****************************************
    // Arbitration clock
    // ****************************************
    // Slow mode grants the RAM every other edge
    assign arb_tick     = !setup_r[SETUP_SLOW_BIT] || phase_r;
    assign net_wr_ready = arb_tick;
    // Pointer wraps naturally at full width
    assign ptr_inc      = ptr_r + RAM_AW'(1);

    // No bounds check: a long packet runs into the next page
    assign cmd_base = (RAM_AW'(bus.wdata[CMD_PAGE_LSB +: 2]) << PAGE_SHIFT)
                    | (RAM_AW'(bus.wdata[CMD_OFS_BIT]) << HALF_SHIFT);

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        ptr_nxt      = ptr_r;
        hi_nxt       = hi_r;
        ainc_nxt     = ainc_r;
        setup_nxt    = setup_r;
        data_nxt     = data_r;
        hold_nxt     = hold_r;
        wr_addr_nxt  = wr_addr_r;
        fetch_nxt    = fetch_r;
        wpend_nxt    = wpend_r;
        phase_nxt    = !phase_r;
        rdata_nxt    = rdata_r;
        tx_start_nxt = tx_start_r;
        rx_start_nxt = rx_start_r;
        tx_arm_nxt   = 1'b0;
        rx_arm_nxt   = 1'b0;
        mem_we       = 1'b0;
        mem_waddr    = wr_addr_r;
        mem_wdata    = hold_r;

        // Network writes outrank host traffic; host work just waits
        if (arb_tick)
        begin
            if (net_wr_en)
            begin
                mem_we    = 1'b1;
                mem_waddr = net_addr;
                mem_wdata = net_wdata;
            end
            else if (wpend_r)
            begin
                mem_we    = 1'b1;
                wpend_nxt = 1'b0;
            end
            else if (fetch_r)
            begin
                data_nxt  = mem_r[ptr_r];
                fetch_nxt = 1'b0;
            end
        end

        if (bus.wr_en)
        begin
            case (bus.addr)
                OFS_PTR_HI: hi_nxt = bus.wdata;
                OFS_PTR_LO:
                begin
                    ptr_nxt   = {hi_r[RAM_AW-9:0], bus.wdata};
                    ainc_nxt  = hi_r[PTR_AINC_BIT];
                    fetch_nxt = 1'b1;
                end
                OFS_DATA:
                begin
                    // Posted write keeps the host cycle short
                    hold_nxt    = bus.wdata;
                    wr_addr_nxt = ptr_r;
                    wpend_nxt   = 1'b1;
                    if (ainc_r)
                    begin
                        ptr_nxt = ptr_inc;
                    end
                end
                OFS_SETUP: setup_nxt = bus.wdata;
                OFS_CMD:
                begin
                    if (bus.wdata[2:0] == CMD_TX_CODE)
                    begin
                        tx_start_nxt = cmd_base;
                        tx_arm_nxt   = 1'b1;
                    end
                    else if (bus.wdata[2:0] == CMD_RX_CODE)
                    begin
                        rx_start_nxt = cmd_base;
                        rx_arm_nxt   = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        if (bus.rd_en)
        begin
            case (bus.addr)
                OFS_PTR_HI: rdata_nxt = {ainc_r, BYTE_ZERO[6:RAM_AW-8],
                                         ptr_r[RAM_AW-1:8]};
                OFS_PTR_LO: rdata_nxt = ptr_r[7:0];
                OFS_DATA:
                begin
                    // Served from the prefetch, never from the array
                    rdata_nxt = data_r;
                    if (ainc_r)
                    begin
                        ptr_nxt   = ptr_inc;
                        fetch_nxt = 1'b1;
                    end
                end
                OFS_SETUP: rdata_nxt = setup_r;
                default:   rdata_nxt = BYTE_ZERO;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ptr_r      <= '0;
            hi_r       <= BYTE_ZERO;
            ainc_r     <= 1'b0;
            setup_r    <= SETUP_RESET;
            data_r     <= BYTE_ZERO;
            hold_r     <= BYTE_ZERO;
            wr_addr_r  <= '0;
            fetch_r    <= 1'b0;
            wpend_r    <= 1'b0;
            phase_r    <= 1'b0;
            rdata_r    <= BYTE_ZERO;
            tx_start_r <= '0;
            rx_start_r <= '0;
            tx_arm_r   <= 1'b0;
            rx_arm_r   <= 1'b0;
        end
        else
        begin
            ptr_r      <= ptr_nxt;
            hi_r       <= hi_nxt;
            ainc_r     <= ainc_nxt;
            setup_r    <= setup_nxt;
            data_r     <= data_nxt;
            hold_r     <= hold_nxt;
            wr_addr_r  <= wr_addr_nxt;
            fetch_r    <= fetch_nxt;
            wpend_r    <= wpend_nxt;
            phase_r    <= phase_nxt;
            rdata_r    <= rdata_nxt;
            tx_start_r <= tx_start_nxt;
            rx_start_r <= rx_start_nxt;
            tx_arm_r   <= tx_arm_nxt;
            rx_arm_r   <= rx_arm_nxt;
        end
    end

    // Array is not reset; contents are undefined at power-up
    always_ff @(posedge ref_clk)
    begin
        if (mem_we)
        begin
            mem_r[mem_waddr] <= mem_wdata;
        end
    end

    assign bus.rdata     = rdata_r;
    assign tx_start_addr = tx_start_r;
    assign rx_start_addr = rx_start_r;
    assign tx_arm        = tx_arm_r;
    assign rx_arm        = rx_arm_r;
    assign slow_arb      = setup_r[SETUP_SLOW_BIT];

endmodule

// *** psra_host.sv ***
`timescale 1ns/100ps
module psra_host
#(
    parameter int RAM_AW     = psra_pkg::RAM_AW,
    parameter int LOAD_GAP   = psra_pkg::LOAD_GAP,
    parameter int ACCESS_GAP = psra_pkg::ACCESS_GAP
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    psra_if.host                   bus,
    input  wire logic              cmd_valid,
    input  psra_pkg::psra_op_e     cmd_op,
    input  wire logic [RAM_AW-1:0] cmd_addr,
    input  wire logic              cmd_ainc,
    input  wire logic [2:0]        cmd_reg,
    input  wire logic [7:0]        cmd_data,
    output logic                   cmd_ready,
    output logic                   cmd_err,
    output logic                   rsp_valid,
    output logic [7:0]             rsp_data
);
    import psra_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_PTR_LO, ST_RD, ST_CAP, ST_WAIT} psra_st_e;

    psra_st_e          st_r,    st_nxt;
    logic [7:0]        cnt_r,   cnt_nxt;
    logic [RAM_AW-1:0] paddr_r, paddr_nxt;
    logic [2:0]        addr_r,  addr_nxt;
    logic [7:0]        wdata_r, wdata_nxt;
    logic              wr_r,    wr_nxt;
    logic              rd_r,    rd_nxt;
    logic              fresh_r, fresh_nxt;
    logic              dir_r,   dir_nxt;
    logic              err_r,   err_nxt;
    logic              rv_r,    rv_nxt;
    logic [7:0]        rsp_r,   rsp_nxt;
    logic              is_data;
    logic              dir_req;

    assign is_data = (cmd_op == PSRA_OP_RD) || (cmd_op == PSRA_OP_WR);
    assign dir_req = (cmd_op == PSRA_OP_WR);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        paddr_nxt = paddr_r;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        wr_nxt    = 1'b0;
        rd_nxt    = 1'b0;
        fresh_nxt = fresh_r;
        dir_nxt   = dir_r;
        err_nxt   = 1'b0;
        rv_nxt    = 1'b0;
        rsp_nxt   = rsp_r;
        case (st_r)
            ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    if (cmd_op == PSRA_OP_PTR)
                    begin
                        // High byte first; low byte commits
                        paddr_nxt = cmd_addr;
                        addr_nxt  = OFS_PTR_HI;
                        wdata_nxt = {cmd_ainc, BYTE_ZERO[6:RAM_AW-8], cmd_addr[RAM_AW-1:8]};
                        wr_nxt    = 1'b1;
                        st_nxt    = ST_PTR_LO;
                    end
                    else if (is_data && !fresh_r && (dir_req != dir_r))
                    begin
                        // Stale prefetch after a turnaround; refuse
                        err_nxt = 1'b1;
                    end
                    else
                    begin
                        addr_nxt  = is_data ? OFS_DATA : cmd_reg;
                        wdata_nxt = cmd_data;
                        if (is_data)
                        begin
                            fresh_nxt = 1'b0;
                            dir_nxt   = dir_req;
                        end
                        if ((cmd_op == PSRA_OP_RD) || (cmd_op == PSRA_OP_REG_RD))
                        begin
                            rd_nxt = 1'b1;
                            st_nxt = ST_RD;
                        end
                        else
                        begin
                            wr_nxt  = 1'b1;
                            cnt_nxt = 8'(ACCESS_GAP);
                            st_nxt  = ST_WAIT;
                        end
                    end
                end
            end
            ST_PTR_LO:
            begin
                addr_nxt  = OFS_PTR_LO;
                wdata_nxt = paddr_r[7:0];
                wr_nxt    = 1'b1;
                fresh_nxt = 1'b1;
                // Lets the prefetch land before the first read
                cnt_nxt   = 8'(LOAD_GAP);
                st_nxt    = ST_WAIT;
            end
            ST_RD: st_nxt = ST_CAP;
            ST_CAP:
            begin
                rsp_nxt = bus.rdata;
                rv_nxt  = 1'b1;
                cnt_nxt = 8'(ACCESS_GAP);
                st_nxt  = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (cnt_r == 8'h00)
                begin
                    st_nxt = ST_IDLE;
                end
                else
                begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r    <= ST_IDLE;
            cnt_r   <= 8'h00;
            paddr_r <= '0;
            addr_r  <= 3'h0;
            wdata_r <= BYTE_ZERO;
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
            fresh_r <= 1'b0;
            dir_r   <= 1'b0;
            err_r   <= 1'b0;
            rv_r    <= 1'b0;
            rsp_r   <= BYTE_ZERO;
        end
        else
        begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            paddr_r <= paddr_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            wr_r    <= wr_nxt;
            rd_r    <= rd_nxt;
            fresh_r <= fresh_nxt;
            dir_r   <= dir_nxt;
            err_r   <= err_nxt;
            rv_r    <= rv_nxt;
            rsp_r   <= rsp_nxt;
        end
    end

    assign cmd_ready = (st_r == ST_IDLE);
    assign cmd_err   = err_r;
    assign rsp_valid = rv_r;
    assign rsp_data  = rsp_r;
    assign bus.addr  = addr_r;
    assign bus.wdata = wdata_r;
    assign bus.wr_en = wr_r;
    assign bus.rd_en = rd_r;

endmodule

// *** psra_if.sv ***
`timescale 1ns/100ps
interface psra_if;
    logic [2:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport dev
    (
        input  addr,
        input  wr_en,
        input  rd_en,
        input  wdata,
        output rdata
    );

    modport host
    (
        output addr,
        output wr_en,
        output rd_en,
        output wdata,
        input  rdata
    );
endinterface

// *** psra_pkg.sv ***
package psra_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int RAM_AW     = 11;
    localparam int RAM_DEPTH  = 2048;
    localparam int PAGE_SHIFT = 9;
    localparam int HALF_SHIFT = 8;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [2:0] OFS_CMD    = 3'h1;
    localparam logic [2:0] OFS_PTR_HI = 3'h2;
    localparam logic [2:0] OFS_PTR_LO = 3'h3;
    localparam logic [2:0] OFS_DATA   = 3'h4;
    localparam logic [2:0] OFS_SETUP  = 3'h7;

    // ****************************************
    // Field positions and codes
    // ****************************************
    localparam int         PTR_AINC_BIT   = 7;
    localparam int         SETUP_SLOW_BIT = 0;
    localparam int         CMD_OFS_BIT    = 5;
    localparam int         CMD_PAGE_LSB   = 3;
    localparam logic [2:0] CMD_TX_CODE    = 3'h3;
    localparam logic [2:0] CMD_RX_CODE    = 3'h4;

    // ****************************************
    // Reset values and host timing
    // ****************************************
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam int         LOAD_GAP    = 3;
    localparam int         ACCESS_GAP  = 3;

    typedef enum logic [2:0] {
        PSRA_OP_PTR,
        PSRA_OP_RD,
        PSRA_OP_WR,
        PSRA_OP_REG_WR,
        PSRA_OP_REG_RD
    } psra_op_e;

endpackage

// *** tb_pointer_sequential_ram_access.sv ***
`timescale 1ns/100ps
module tb_pointer_sequential_ram_access;
    import psra_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    psra_op_e    cmd_op = PSRA_OP_RD;
    logic [10:0] cmd_addr = 11'h000;
    logic        cmd_ainc = 1'b0;
    logic [2:0]  cmd_reg = 3'h0;
    logic [7:0]  cmd_data = 8'h00;
    logic        net_wr_en = 1'b0;
    logic [10:0] net_addr = 11'h000;
    logic [7:0]  net_wdata = 8'h00;
    logic        cmd_ready, cmd_err, rsp_valid, net_wr_ready;
    logic        tx_arm, rx_arm, slow_arb;
    logic [7:0]  rsp_data, rv;
    logic [10:0] tx_start_addr, rx_start_addr;
    logic        re;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles = 0;

    psra_if bus_if();
    psra_device psra_device_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus_if.dev),
        .net_wr_en(net_wr_en), .net_addr(net_addr), .net_wdata(net_wdata),
        .net_wr_ready(net_wr_ready), .tx_start_addr(tx_start_addr),
        .rx_start_addr(rx_start_addr), .tx_arm(tx_arm), .rx_arm(rx_arm),
        .slow_arb(slow_arb));
    psra_host psra_host_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus_if.host),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_ainc(cmd_ainc), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .cmd_err(cmd_err), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));
    psra_chk psra_chk_inst (.ref_clk(ref_clk), .rst(rst), .addr(bus_if.addr),
        .wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en), .wdata(bus_if.wdata),
        .rdata(bus_if.rdata));

    // ****************************************
    // Clock, watchdog, common tasks
    // ****************************************
    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t watchdog expired", $time);
            summarize();
        end
    end

    task automatic expect_eq(input logic [10:0] got, input logic [10:0] exp, input string what);
        compares = compares + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Ready is judged at the falling edge so the take edge is never raced
    task automatic issue(input psra_op_e op, input logic [10:0] a, input logic ai,
                         input logic [2:0] r, input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_ainc <= ai;
        cmd_reg <= r;
        cmd_data <= d;
        k = 0;
        @(negedge ref_clk);
        while (cmd_ready !== 1'b1 && k < 50)
        begin
            @(negedge ref_clk);
            k = k + 1;
        end
        if (k == 50)
        begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t host never ready", $time);
        end
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
    endtask

    task automatic xfer(input psra_op_e op, input logic [10:0] a, input logic ai,
                        input logic [2:0] r, input logic [7:0] d);
        int k;
        issue(op, a, ai, r, d);
        // Unknown until a real response arrives, so a lost read fails
        rv = 8'hXX;
        re = 1'b0;
        for (k = 0; k < 12; k++)
        begin
            @(negedge ref_clk);
            if (rsp_valid === 1'b1 || cmd_err === 1'b1)
            begin
                rv = (rsp_valid === 1'b1) ? rsp_data : 8'hXX;
                re = cmd_err;
                break;
            end
        end
    endtask

    task automatic net_write(input logic [10:0] a, input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        net_wr_en <= 1'b1;
        net_addr <= a;
        net_wdata <= d;
        k = 0;
        @(negedge ref_clk);
        while (net_wr_ready !== 1'b1 && k < 8)
        begin
            @(negedge ref_clk);
            k = k + 1;
        end
        if (k == 8)
        begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t network write never granted", $time);
        end
        @(posedge ref_clk);
        net_wr_en <= 1'b0;
    endtask

    task automatic count_ready(input logic [10:0] exp);
        logic [10:0] n;
        n = 11'h000;
        repeat (8)
        begin
            @(negedge ref_clk);
            if (net_wr_ready === 1'b1)
                n = n + 11'h001;
        end
        expect_eq(n, exp, "arbitration ticks in 8 cycles");
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        xfer(PSRA_OP_REG_RD, 11'h000, 1'b0, OFS_SETUP, 8'h00);
        expect_eq({3'h0, rv}, {3'h0, SETUP_RESET}, "setup after reset");
        expect_eq({10'h000, slow_arb}, 11'h000, "slow flag after reset");
        xfer(PSRA_OP_REG_RD, 11'h000, 1'b0, OFS_PTR_LO, 8'h00);
        expect_eq({3'h0, rv}, 11'h000, "pointer low after reset");
        xfer(PSRA_OP_REG_RD, 11'h000, 1'b0, 3'h5, 8'h00);
        expect_eq({3'h0, rv}, 11'h000, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_stream();
        int i;
        xfer(PSRA_OP_PTR, 11'h7FE, 1'b1, 3'h0, 8'h00);
        for (i = 0; i < 3; i++)
            xfer(PSRA_OP_WR, 11'h000, 1'b0, 3'h0, 8'hA1 + 8'(i));
        xfer(PSRA_OP_REG_RD, 11'h000, 1'b0, OFS_PTR_HI, 8'h00);
        expect_eq({3'h0, rv}, 11'h080, "pointer high after wrap");
        xfer(PSRA_OP_REG_RD, 11'h000, 1'b0, OFS_PTR_LO, 8'h00);
        expect_eq({3'h0, rv}, 11'h001, "pointer low after wrap");
        xfer(PSRA_OP_RD, 11'h000, 1'b0, 3'h0, 8'h00);
        expect_eq({10'h000, re}, 11'h001, "turnaround refused");
        xfer(PSRA_OP_PTR, 11'h7FE, 1'b1, 3'h0, 8'h00);
        for (i = 0; i < 3; i++)
        begin
            xfer(PSRA_OP_RD, 11'h000, 1'b0, 3'h0, 8'h00);
            expect_eq({3'h0, rv}, {3'h0, 8'hA1 + 8'(i)}, "streamed read");
        end
        // Without auto-increment both writes land on one byte
        xfer(PSRA_OP_PTR, 11'h010, 1'b0, 3'h0, 8'h00);
        xfer(PSRA_OP_WR, 11'h000, 1'b0, 3'h0, 8'h5A);
        xfer(PSRA_OP_WR, 11'h000, 1'b0, 3'h0, 8'h6B);
        xfer(PSRA_OP_PTR, 11'h010, 1'b0, 3'h0, 8'h00);
        for (i = 0; i < 2; i++)
        begin
            xfer(PSRA_OP_RD, 11'h000, 1'b0, 3'h0, 8'h00);
            expect_eq({3'h0, rv}, 11'h06B, "fixed address read");
        end
        xfer(PSRA_OP_REG_RD, 11'h000, 1'b0, OFS_PTR_LO, 8'h00);
        expect_eq({3'h0, rv}, 11'h010, "pointer held");
        $display("test stream done");
    endtask

    task automatic t_net();
        net_write(11'h1FF, 8'h11);
        net_write(11'h200, 8'h22);
        xfer(PSRA_OP_PTR, 11'h1FF, 1'b1, 3'h0, 8'h00);
        xfer(PSRA_OP_RD, 11'h000, 1'b0, 3'h0, 8'h00);
        expect_eq({3'h0, rv}, 11'h011, "net byte at page end");
        xfer(PSRA_OP_RD, 11'h000, 1'b0, 3'h0, 8'h00);
        expect_eq({3'h0, rv}, 11'h022, "net byte past page end");
        $display("test net done");
    endtask

    task automatic t_cmds();
        int c, p, f, k;
        logic        arm;
        logic [10:0] st, exp;
        for (c = 0; c < 2; c++)
            for (p = 0; p < 4; p++)
                for (f = 0; f < 2; f++)
                begin
                    exp = 11'((p << PAGE_SHIFT) + (f << HALF_SHIFT));
                    issue(PSRA_OP_REG_WR, 11'h000, 1'b0, OFS_CMD,
                          {2'b00, 1'(f), 2'(p), (c == 0) ? CMD_TX_CODE : CMD_RX_CODE});
                    arm = 1'b0;
                    st = 11'h7FF;
                    for (k = 0; k < 6 && arm == 1'b0; k++)
                    begin
                        @(negedge ref_clk);
                        arm = (c == 0) ? (tx_arm === 1'b1) : (rx_arm === 1'b1);
                        st = (c == 0) ? tx_start_addr : rx_start_addr;
                    end
                    expect_eq({10'h000, arm}, 11'h001, "buffer armed");
                    expect_eq(st, exp, "buffer start");
                end
        // An unknown code must arm nothing
        issue(PSRA_OP_REG_WR, 11'h000, 1'b0, OFS_CMD, 8'h05);
        arm = 1'b0;
        repeat (6)
        begin
            @(negedge ref_clk);
            arm = arm | (tx_arm === 1'b1) | (rx_arm === 1'b1);
        end
        expect_eq({10'h000, arm}, 11'h000, "ignored command");
        xfer(PSRA_OP_REG_RD, 11'h000, 1'b0, OFS_CMD, 8'h00);
        expect_eq({3'h0, rv}, 11'h000, "command reads zero");
        $display("test commands done");
    endtask

    task automatic t_slow();
        xfer(PSRA_OP_REG_WR, 11'h000, 1'b0, OFS_SETUP, 8'h01);
        expect_eq({10'h000, slow_arb}, 11'h001, "slow flag set");
        count_ready(11'h004);
        xfer(PSRA_OP_PTR, 11'h3FF, 1'b1, 3'h0, 8'h00);
        xfer(PSRA_OP_WR, 11'h000, 1'b0, 3'h0, 8'h3C);
        xfer(PSRA_OP_PTR, 11'h3FF, 1'b1, 3'h0, 8'h00);
        xfer(PSRA_OP_RD, 11'h000, 1'b0, 3'h0, 8'h00);
        expect_eq({3'h0, rv}, 11'h03C, "slow round trip");
        xfer(PSRA_OP_REG_RD, 11'h000, 1'b0, OFS_SETUP, 8'h00);
        expect_eq({3'h0, rv}, 11'h001, "setup readback");
        xfer(PSRA_OP_REG_WR, 11'h000, 1'b0, OFS_SETUP, 8'h00);
        count_ready(11'h008);
        $display("test slow done");
    endtask

    task automatic summarize();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_stream();
        t_net();
        t_cmds();
        t_slow();
        summarize();
    end
endmodule
